//--- debug_status_pkg.sv
package debug_status_pkg;

   // ----------------------------------------------------------------
   // register map (global addresses, full 24-bit address used for decode)
   // ----------------------------------------------------------------
   localparam logic [23:0] STATUS_ADDR   = 24'h7fff01;
   localparam logic [23:0] CCR_LOW_ADDR  = 24'h7fff06;

   // ----------------------------------------------------------------
   // status register field positions
   // ----------------------------------------------------------------
   localparam int ENABLE_BIT   = 7;
   localparam int ACTIVE_BIT   = 6;
   localparam int SDV_BIT      = 4;
   localparam int TRACE_BIT    = 3;
   localparam int DEBUG_CLOCK_SWITCH_BIT    = 2;
   localparam int UNSECURE_FLAG_BIT    = 1;
   localparam logic [7:0] STATUS_IMPL_MASK = 8'hde;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] CCR_LOW_RESET_SSC = 8'hd8;
   localparam logic [7:0] CCR_LOW_RESET_OTH = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_SWITCH_WAIT_CYCLES = 150;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_SPECIAL_SINGLE,
      MODE_EMULATION,
      MODE_OTHER
   } chip_mode_t;

   typedef enum logic [1:0] {
      LINK_CLK_OSC_BUS,
      LINK_CLK_ALTERNATE,
      LINK_CLK_PLL_BUS
   } link_clk_sel_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        hw_cmd;
      logic        fw_exit;
      logic [23:0] addr;
      logic [7:0]  wdata;
   } reg_access_t;

   typedef struct packed {
      logic cmd_received;
      logic data_shifted;
      logic trace_start;
      logic go_resume;
   } cmd_events_t;

endpackage : debug_status_pkg

//--- link_clock_select.sv
`timescale 1ns/10ps
`default_nettype none

module link_clock_select
   import debug_status_pkg::*;
(
   input  wire logic   i_pll_select,
   input  wire logic   i_clock_switch,
   output link_clk_sel_t o_sel
);

   always_comb begin
      if (!i_pll_select) begin
         o_sel = LINK_CLK_OSC_BUS;  // see (R11)
      end else if (!i_clock_switch) begin
         o_sel = LINK_CLK_ALTERNATE;
      end else begin
         o_sel = LINK_CLK_PLL_BUS;
      end
   end

endmodule : link_clock_select

`default_nettype wire

//--- sync_2ff.sv
`timescale 1ns/10ps
`default_nettype none

module sync_2ff #(
   parameter int WIDTH = 1
) (
   input  wire logic             i_clk,
   input  wire logic             i_resetn,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;

endmodule : sync_2ff

`default_nettype wire

//--- background_debug_status_regs.sv
// Function
// (R1) enable gates activation; hardware commands still allowed
// (R2) firmware sets enable in special mode; hardware otherwise
// (R3) secured: hold enable, block emulation operations
// (R4) entry sets active, maps firmware table
// (R5) active cleared only by firmware exit store
// (R6) set data valid after data phase
// (R7) clear data valid on command or exit
// (R8) trace set on single step until go
// (R9) clock switch writable by hardware command only
// (R10) host waits 150 link clocks after switch
// (R11) link clock chosen from select and switch
// (R12) link fully synchronised to alternate clock
// (R13) acknowledge uses new clock rate immediately
// (R14) emulation reset sets clock switch
// (R15) unsecure clear on secure entry, firmware writes
// (R16) erase pass sets unsecure, else stays clear
// (R17) unsecure reads state; permits security writes
// (R18) unchanged security bits resecure at reset
// (R19) entry copies condition codes low byte
// (R20) holding resets 0xd8 special, zero otherwise
// (R21) holding reached only by debug when unsecured
// (R22) registers reachable only by debug register commands
// (R23) status bits 5 and 0 read zero
// (R24) active writes ignored except firmware exit
`timescale 1ns/10ps
`default_nettype none

module background_debug_status_regs
   import debug_status_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire chip_mode_t  i_mode,
   input  wire logic        i_secured,
   input  wire logic        i_pll_select,
   input  wire reg_access_t i_acc,
   input  wire cmd_events_t i_evt,
   input  wire logic        i_enter_debug,
   input  wire logic [7:0]  i_ccr_low,
   input  wire logic        i_erase_done,
   input  wire logic        i_erase_pass,
   output logic [7:0]       o_rdata,
   output logic             o_rvalid,
   output logic [7:0]       o_status,
   output logic [7:0]       o_ccr_restore,
   output logic             o_debug_active,
   output logic             o_firmware_mapped,
   output logic             o_secure_table_on,
   output logic             o_ops_blocked,
   output logic             o_sec_bits_writable,
   output logic             o_activate_refused,
   output logic [1:0]       o_link_clk_sel
);

   // ----------------------------------------------------------------
   // straps caught after reset release
   // ----------------------------------------------------------------
   // mode and security come from pins and are synchronised before use;
   // async reset leaves every flop at a constant, straps load three cycles later
   logic [1:0]    mode_s;
   logic          init_q,  init_d;
   logic          mode_ssc, mode_emu, secured;
   logic          erase_done_s, erase_pass_s;

   sync_2ff #(.WIDTH(5)) u_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  ({i_mode, i_secured, i_erase_done, i_erase_pass}),
      .o_sync   ({mode_s, secured, erase_done_s, erase_pass_s})
   );

   assign mode_ssc = (mode_s == MODE_SPECIAL_SINGLE);
   assign mode_emu = (mode_s == MODE_EMULATION);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic       enable_q,   enable_d;
   logic       active_q,   active_d;
   logic       sdv_q,      sdv_d;
   logic       trace_q,    trace_d;
   logic       debug_clock_switch_q,    debug_clock_switch_d;
   logic       unsecure_flag_q,    unsecure_flag_d;
   logic       sectab_q,   sectab_d;
   logic       erase_seen_q, erase_seen_d;
   logic [7:0] ccrl_q,     ccrl_d;
   logic [7:0] rdata_q,    rdata_d;
   logic       rvalid_q,   rvalid_d;
   logic       refused_q,  refused_d;
   logic [1:0] ready_q,    ready_d;

   function automatic logic hits(input reg_access_t a, input logic [23:0] adr);
      hits = a.valid && (a.addr == adr);
   endfunction : hits

   logic          access_ok;
   logic          wr_status, wr_ccrl, wr_unsecure_flag;
   logic          unsecured;
   link_clk_sel_t link_sel;
   logic [7:0]    status_view;

   // registers answer only while the device is unsecured or the erase
   // check has released it
   assign unsecured = !secured || unsecure_flag_q;
   assign access_ok = unsecured && !(mode_emu && secured);  // see (R3) see (R21)
   assign wr_status = access_ok && i_acc.write && hits(i_acc, STATUS_ADDR);  // see (R22)
   assign wr_ccrl   = access_ok && i_acc.write && hits(i_acc, CCR_LOW_ADDR);
   assign wr_unsecure_flag  = sectab_q && mode_ssc && !i_acc.hw_cmd && i_acc.write
                      && hits(i_acc, STATUS_ADDR);  // see (R15)

   always_comb begin
      status_view = 8'h00;
      status_view[ENABLE_BIT] = enable_q;
      status_view[ACTIVE_BIT] = active_q;
      status_view[SDV_BIT]    = sdv_q;
      status_view[TRACE_BIT]  = trace_q;
      status_view[DEBUG_CLOCK_SWITCH_BIT]  = debug_clock_switch_q;
      status_view[UNSECURE_FLAG_BIT]  = unsecure_flag_q;
      status_view = status_view & STATUS_IMPL_MASK;  // see (R23)
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      init_d       = 1'b1;
      enable_d     = enable_q;
      active_d     = active_q;
      sdv_d        = sdv_q;
      trace_d      = trace_q;
      debug_clock_switch_d      = debug_clock_switch_q;
      unsecure_flag_d      = unsecure_flag_q;
      sectab_d     = sectab_q;
      erase_seen_d = erase_seen_q;
      ccrl_d       = ccrl_q;
      rdata_d      = rdata_q;
      rvalid_d     = 1'b0;
      refused_d    = 1'b0;
      ready_d      = ready_q;

      if (!init_q) begin
         // first three cycles after release: mode dependent reset values
         ready_d  = {ready_q[0], 1'b1};
         enable_d = mode_emu && !secured;                       // see (R2) see (R3)
         active_d = mode_ssc;
         debug_clock_switch_d  = mode_emu;                                   // see (R14)
         unsecure_flag_d  = 1'b0;                                       // see (R15) see (R18)
         sectab_d = mode_ssc && secured;                        // see (R15)
         ccrl_d   = mode_ssc ? CCR_LOW_RESET_SSC : CCR_LOW_RESET_OTH;  // see (R20)
         init_d   = ready_q[1];
      end else begin
         // special mode firmware enables when unsecured or once erase check is done
         if (mode_ssc && !enable_q && (!secured || erase_seen_q)) begin
            enable_d = 1'b1;                                    // see (R2) see (R3)
         end
         if (mode_ssc && secured && erase_done_s && !erase_seen_q) begin
            erase_seen_d = 1'b1;
            if (erase_pass_s) begin
               unsecure_flag_d  = 1'b1;                                 // see (R16)
               sectab_d = 1'b0;
            end
         end

         // activation
         if (i_enter_debug) begin
            if (enable_q && access_ok) begin
               active_d = 1'b1;                                 // see (R1) see (R4)
               ccrl_d   = i_ccr_low;                            // see (R19)
            end else begin
               refused_d = 1'b1;                                // see (R1)
            end
         end

         // shift data valid: set wins over clear in one cycle
         if (i_evt.cmd_received || (active_q && !active_d)) begin
            sdv_d = 1'b0;                                       // see (R7)
         end
         if (i_evt.go_resume) begin
            trace_d = 1'b0;                                     // see (R8)
         end

         // register writes
         if (wr_status) begin
            enable_d = i_acc.wdata[ENABLE_BIT];
            if (i_acc.hw_cmd) begin
               debug_clock_switch_d = i_acc.wdata[DEBUG_CLOCK_SWITCH_BIT];                // see (R9) see (R13)
            end
            if (i_acc.fw_exit && !i_acc.wdata[ACTIVE_BIT]) begin
               active_d = 1'b0;                                 // see (R5) see (R24)
               sdv_d    = 1'b0;                                 // see (R7)
            end
         end
         if (wr_unsecure_flag) begin
            unsecure_flag_d = i_acc.wdata[UNSECURE_FLAG_BIT];                   // see (R15)
         end
         if (wr_ccrl) begin
            ccrl_d = i_acc.wdata;                               // see (R19) see (R21)
         end

         if (i_evt.data_shifted) begin
            sdv_d = 1'b1;                                       // see (R6)
         end
         if (i_evt.trace_start) begin
            trace_d = 1'b1;                                     // see (R8)
         end

         // reads
         if (i_acc.valid && !i_acc.write) begin
            rvalid_d = 1'b1;
            if (!access_ok) begin
               rdata_d = 8'h00;                                 // see (R21)
            end else if (hits(i_acc, STATUS_ADDR)) begin
               rdata_d = status_view;                           // see (R17) see (R23)
            end else if (hits(i_acc, CCR_LOW_ADDR)) begin
               rdata_d = ccrl_q;
            end else begin
               rdata_d = 8'h00;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         init_q       <= 1'b0;
         ready_q      <= 2'b00;
         enable_q     <= 1'b0;
         active_q     <= 1'b0;
         sdv_q        <= 1'b0;
         trace_q      <= 1'b0;
         debug_clock_switch_q      <= 1'b0;
         unsecure_flag_q      <= 1'b0;
         sectab_q     <= 1'b0;
         erase_seen_q <= 1'b0;
         ccrl_q       <= 8'h00;
         rdata_q      <= 8'h00;
         rvalid_q     <= 1'b0;
         refused_q    <= 1'b0;
      end else begin
         init_q       <= init_d;
         ready_q      <= ready_d;
         enable_q     <= enable_d;
         active_q     <= active_d;
         sdv_q        <= sdv_d;
         trace_q      <= trace_d;
         debug_clock_switch_q      <= debug_clock_switch_d;
         unsecure_flag_q      <= unsecure_flag_d;
         sectab_q     <= sectab_d;
         erase_seen_q <= erase_seen_d;
         ccrl_q       <= ccrl_d;
         rdata_q      <= rdata_d;
         rvalid_q     <= rvalid_d;
         refused_q    <= refused_d;
      end
   end

   // ----------------------------------------------------------------
   // link clock selection
   // ----------------------------------------------------------------
   // the select follows the written switch in the same cycle so the
   // acknowledge of that write already runs at the new rate; the link
   // itself resynchronises to whichever clock is chosen
   logic pll_sel_s;
   logic [1:0] link_sel_q;

   sync_2ff #(.WIDTH(1)) u_pll_sync (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_async  (i_pll_select),
      .o_sync   (pll_sel_s)
   );

   link_clock_select u_clock_select_reg (
      .i_pll_select   (pll_sel_s),
      .i_clock_switch (debug_clock_switch_d),                                // see (R13)
      .o_sel          (link_sel)                                // see (R11) see (R12)
   );

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         link_sel_q <= 2'b00;
      end else begin
         link_sel_q <= 2'(link_sel);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic [7:0] status_q;
   logic [7:0] restore_q;
   logic       mapped_q, sectab_out_q, blocked_q, secw_q, act_out_q;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         status_q     <= 8'h00;
         restore_q    <= 8'h00;
         mapped_q     <= 1'b0;
         sectab_out_q <= 1'b0;
         blocked_q    <= 1'b0;
         secw_q       <= 1'b0;
         act_out_q    <= 1'b0;
      end else begin
         status_q     <= status_view;
         restore_q    <= ccrl_q;                                // see (R19)
         act_out_q    <= active_q;
         mapped_q     <= active_q;                              // see (R4) see (R5)
         sectab_out_q <= sectab_q;                              // see (R16)
         blocked_q    <= !access_ok;                            // see (R3)
         secw_q       <= unsecure_flag_q;                               // see (R17)
      end
   end

   assign o_rdata             = rdata_q;
   assign o_rvalid            = rvalid_q;
   assign o_status            = status_q;
   assign o_ccr_restore       = restore_q;
   assign o_debug_active      = act_out_q;
   assign o_firmware_mapped   = mapped_q;
   assign o_secure_table_on   = sectab_out_q;
   assign o_ops_blocked       = blocked_q;
   assign o_sec_bits_writable = secw_q;
   assign o_activate_refused  = refused_q;
   assign o_link_clk_sel      = link_sel_q;

endmodule : background_debug_status_regs

`default_nettype wire

//--- debug_status_sva.sv
`timescale 1ns/10ps
`default_nettype none

module debug_status_sva
   import debug_status_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   input  wire logic        i_pll_select,
   input  wire reg_access_t i_acc,
   input  wire cmd_events_t i_evt,
   input  wire logic [7:0]  o_rdata,
   input  wire logic        o_rvalid,
   input  wire logic [7:0]  o_status,
   input  wire logic        o_debug_active,
   input  wire logic [1:0]  o_link_clk_sel
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   // ------------------------------------------------------------
   // settle counter: mode reset values land a few cycles late
   // ------------------------------------------------------------
   logic [3:0] settle_q;
   logic [3:0] settle_d;
   logic       settled;
   logic       st_wr;
   logic       fx_wr;
   assign settled = settle_q == 4'hf;
   assign st_wr = i_acc.valid && i_acc.write && i_acc.hw_cmd && i_acc.addr == STATUS_ADDR;
   assign fx_wr = i_acc.valid && i_acc.write && i_acc.fw_exit && i_acc.addr == STATUS_ADDR;
   always_comb settle_d = settled ? settle_q : settle_q + 4'h1;
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) settle_q <= 4'h0;
      else settle_q <= settle_d;
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   chk_read_answer: assert property (
      settled && i_acc.valid && !i_acc.write |=> o_rvalid)
      else $error("read request not answered next cycle");
   chk_status_zero: assert property (o_status[5] == 1'b0 && o_status[0] == 1'b0)
      else $error("unimplemented status bit reads one");
   chk_link_osc: assert property ((!i_pll_select)[*5] |-> o_link_clk_sel == 2'h0)
      else $error("link clock not oscillator bus with pll off");
   chk_rdata_hold: assert property (!o_rvalid |-> $stable(o_rdata))
      else $error("read data moved without a read");
   chk_active_exit: assert property (settled && $fell(o_debug_active)
      |-> $past(fx_wr, 1) || $past(fx_wr, 2) || $past(fx_wr, 3))
      else $error("active cleared without firmware exit store");
   chk_debug_clock_switch_hw: assert property (settled && $changed(o_status[DEBUG_CLOCK_SWITCH_BIT])
      |-> $past(st_wr, 1) || $past(st_wr, 2) || $past(st_wr, 3))
      else $error("clock switch changed without hardware write");
   chk_sdv_set: assert property (
      settled && i_evt.data_shifted |-> ##[1:3] o_status[SDV_BIT])
      else $error("data valid not set after data phase");
   chk_trace_set: assert property (settled && $rose(o_status[TRACE_BIT])
      |-> $past(i_evt.trace_start, 1) || $past(i_evt.trace_start, 2)
          || $past(i_evt.trace_start, 3))
      else $error("trace set without single step");

   cover property (o_rvalid);
   cover property ($fell(o_debug_active));
   cover property (o_link_clk_sel == 2'h1);
endmodule : debug_status_sva

bind background_debug_status_regs debug_status_sva chk_u (
   .i_clk(i_clk), .i_resetn(i_resetn), .i_pll_select(i_pll_select), .i_acc(i_acc),
   .i_evt(i_evt), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_status(o_status),
   .o_debug_active(o_debug_active), .o_link_clk_sel(o_link_clk_sel));

`default_nettype wire

//--- debug_host_model.sv
`timescale 1ns/10ps
`default_nettype none

module debug_host_model
   import debug_status_pkg::*;
(
   input  wire logic       i_clk,
   input  wire logic       i_rvalid,
   input  wire logic [7:0] i_rdata,
   output reg_access_t     o_acc,
   output cmd_events_t     o_evt
);
   initial begin
      o_acc = '0;
      o_evt = '0;
   end

   // ------------------------------------------------------------
   // register commands, one access cycle each
   // ------------------------------------------------------------
   task automatic access(input logic w, input logic hw, input logic fx,
                         input logic [23:0] a, input logic [7:0] d, output logic [7:0] rd);
      o_acc = '{valid: 1'b1, write: w, hw_cmd: hw, fw_exit: fx, addr: a, wdata: d};
      @(negedge i_clk);
      // released bus shows inverted leftovers, never the old value
      o_acc = '{valid: 1'b0, write: 1'b0, hw_cmd: 1'b0, fw_exit: 1'b0, addr: ~a, wdata: ~d};
      rd = 8'hxx;
      if (!w && i_rvalid) rd = i_rdata;
      @(negedge i_clk);
      if (w && hw && a == STATUS_ADDR) repeat (CLK_SWITCH_WAIT_CYCLES) @(negedge i_clk);
   endtask : access

   task automatic pulse(input cmd_events_t e);
      o_evt = e;
      @(negedge i_clk);
      o_evt = '0;
      @(negedge i_clk);
   endtask : pulse
endmodule : debug_host_model

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top
   import debug_status_pkg::*;
;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   chip_mode_t  mode = MODE_OTHER;
   logic        secured = 1'b0, pll_sel = 1'b0, enter = 1'b0;
   logic        erase_done = 1'b0, erase_pass = 1'b0;
   logic [7:0]  ccr_in = 8'h00;
   reg_access_t acc;
   cmd_events_t evt;
   logic [7:0]  rdata, status, ccr_restore, rd, v;
   logic        rvalid, active, fw_mapped, refused, sec_wr, sec_tab, blocked;
   logic [1:0]  link_sel;
   int          errors = 0;
   int          n_compared = 0;

   always #12.5 clk = ~clk;

   debug_host_model host_u (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_acc(acc),
      .o_evt(evt));
   background_debug_status_regs dut_u (.i_clk(clk), .i_resetn(resetn), .i_mode(mode),
      .i_secured(secured), .i_pll_select(pll_sel), .i_acc(acc), .i_evt(evt),
      .i_enter_debug(enter), .i_ccr_low(ccr_in), .i_erase_done(erase_done),
      .i_erase_pass(erase_pass), .o_rdata(rdata), .o_rvalid(rvalid), .o_status(status),
      .o_ccr_restore(ccr_restore), .o_debug_active(active), .o_firmware_mapped(fw_mapped),
      .o_secure_table_on(sec_tab), .o_ops_blocked(blocked), .o_sec_bits_writable(sec_wr),
      .o_activate_refused(refused), .o_link_clk_sel(link_sel));

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic complete_run();
      if (errors == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run

   function automatic logic [7:0] exp_status(input chip_mode_t m);
      case (m)
         MODE_SPECIAL_SINGLE: return 8'hc0;
         MODE_EMULATION:      return 8'h84;
         default:             return 8'h00;
      endcase
   endfunction : exp_status

   function automatic logic [1:0] exp_sel(input logic p, input logic s);
      if (!p) return 2'h0;
      return s ? 2'h2 : 2'h1;
   endfunction : exp_sel

   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n

   task automatic do_reset(input chip_mode_t m, input logic s);
      @(negedge clk);
      mode = m;
      secured = s;
      resetn = 1'b0;
      wait_n(5);
      resetn = 1'b1;
      wait_n(6);
   endtask : do_reset

   task automatic rw(input logic hw, input logic fx, input logic [23:0] a, input logic [7:0] d);
      host_u.access(1'b1, hw, fx, a, d, rd);
   endtask : rw

   task automatic rd_chk(input logic [23:0] a, input logic [7:0] exp);
      host_u.access(1'b0, 1'b1, 1'b0, a, 8'h00, rd);
      check(rd, exp);
   endtask : rd_chk

   task automatic enter_pulse();
      enter = 1'b1;
      @(negedge clk);
      enter = 1'b0;
   endtask : enter_pulse

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      void'($urandom(94));
      for (int i = 0; i < 3; i++) begin
         do_reset(chip_mode_t'(i), 1'b0);
         rd_chk(STATUS_ADDR, exp_status(chip_mode_t'(i)));
         rd_chk(CCR_LOW_ADDR, (i == 0) ? CCR_LOW_RESET_SSC : CCR_LOW_RESET_OTH);
         check({7'h0, blocked}, 8'h00);
      end
      rw(1'b1, 1'b0, STATUS_ADDR, 8'ha5);
      rd_chk(STATUS_ADDR, 8'h84);
      rw(1'b0, 1'b0, STATUS_ADDR, 8'h21);
      rd_chk(STATUS_ADDR, 8'h04);
      rd_chk(24'h7fff03, 8'h00);
      enter_pulse();
      check({7'h0, refused}, 8'h01);
      wait_n(4);
      check({7'h0, active}, 8'h00);
      rw(1'b1, 1'b0, STATUS_ADDR, 8'h80);
      v = 8'($urandom);
      ccr_in = v;
      enter_pulse();
      wait_n(4);
      ccr_in = ~v;
      check({6'h0, active, fw_mapped}, 8'h03);
      rd_chk(CCR_LOW_ADDR, v);
      v = 8'($urandom);
      rw(1'b1, 1'b0, CCR_LOW_ADDR, v);
      wait_n(2);
      check(ccr_restore, v);
      host_u.pulse(cmd_events_t'(4'b0100));
      check(status & 8'h18, 8'h10);
      host_u.pulse(cmd_events_t'(4'b0010));
      host_u.pulse(cmd_events_t'(4'b1000));
      check(status & 8'h18, 8'h08);
      host_u.pulse(cmd_events_t'(4'b0001));
      check(status & 8'h18, 8'h00);
      rw(1'b1, 1'b0, STATUS_ADDR, 8'h80);
      wait_n(3);
      check({7'h0, active}, 8'h01);
      rw(1'b0, 1'b1, STATUS_ADDR, 8'h80);
      wait_n(3);
      check({7'h0, active}, 8'h00);
      for (int i = 0; i < 8; i++) begin
         v = 8'($urandom);
         pll_sel = v[0];
         rw(1'b1, 1'b0, STATUS_ADDR, {5'h10, v[1], 2'h0});
         check({6'h0, link_sel}, {6'h0, exp_sel(v[0], v[1])});
      end
      for (int i = 1; i < 3; i++) begin
         do_reset(chip_mode_t'(i), 1'b1);
         rd_chk(CCR_LOW_ADDR, 8'h00);
         rd_chk(STATUS_ADDR, 8'h00);
         check({7'h0, blocked}, 8'h01);
      end
      for (int i = 0; i < 2; i++) begin
         do_reset(MODE_SPECIAL_SINGLE, 1'b1);
         check({7'h0, sec_wr}, 8'h00);
         check({6'h0, sec_tab, blocked}, 8'h03);
         erase_pass = i[0];
         erase_done = 1'b1;
         wait_n(8);
         check({7'h0, sec_wr}, {7'h0, i[0]});
         check({6'h0, sec_tab, blocked}, {6'h0, !i[0], !i[0]});
         erase_done = 1'b0;
         erase_pass = 1'b0;
      end
      complete_run();
   end

   // run needs about 1850 cycles; cut off well beyond that
   initial begin
      #200000;
      errors++;
      complete_run();
   end
endmodule : tb_top

`default_nettype wire
